// File: rtl/mpp_core.sv
// Motor power PWM core with AXI4-Lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// [R1] Generators 0..3 drive pins 0..7 as even/odd pairs.
// [R2] FULL parameter picks four generators/eight pins or three/six.
// [R3] Complementary pair drives even pin as inverse of odd pin.
// [R4] Programmable dead gap keeps both pair switches off between transitions.
// [R5] 12-bit time base with selectable prescaler and period postscaler.
// [R6] Count, period, event compare and four duties are buffered 16-bit values; here the count is 12 bits; count and event compare are written directly.
// [R7] Duty compare uses up to 14 bits, limited by period.
// [R8] Edge-aligned, center-aligned and single-pulse modes supported.
// [R9] Center-aligned double-update mode interrupts at top and bottom.
// [R10] Special event compare emits trigger pulse for other peripherals.
// [R11] Software can override each output to a fixed state.
// [R12] Debug halt forces all outputs inactive.
// [R13] Prescale codes 00..11 divide base clock by 1, 4, 16, 64.
// [R14] Mode codes: free, single-shot, up/down, up/down double-update.
// [R15] Count runs only while enabled; disabling keeps the count.
// [R16] Buffered period and duties load only at period boundary; here they also load while the time base is stopped.
module mpp_core
  import mpp_pkg::*;
#(
  parameter bit FULL = 1'b1,
  parameter int DT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_halt,
  output logic [7:0] pwm_out,
  output logic [7:0] pwm_en,
  output logic special_event_trig,
  output logic irq
);

  localparam int NUM_GEN = FULL ? 4 : 3; // R2

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Byte-lane merge for 16-bit buffers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  // Last prescaler count: base clock is aclk/4, then 1, 4, 16, 64
  function automatic logic [7:0] presc_last(input logic [1:0] code);
    unique case (code)
      2'h0: presc_last = 8'h03;
      2'h1: presc_last = 8'h0f;
      2'h2: presc_last = 8'h3f;
      2'h3: presc_last = 8'hff;
    endcase
  endfunction : presc_last

  // Pin enable code to pin mask; the small variant never enables pair 3
  function automatic logic [7:0] pin_mask(input logic [2:0] code);
    unique case (code)
      3'h0: pin_mask = 8'h00;
      3'h1: pin_mask = 8'h02;
      3'h2: pin_mask = 8'h03;
      3'h3: pin_mask = 8'h0f;
      3'h4: pin_mask = 8'h3f;
      3'h5: pin_mask = FULL ? 8'hff : 8'h3f;
      3'h6: pin_mask = 8'h0a;
      3'h7: pin_mask = FULL ? 8'haa : 8'h2a;
    endcase
  endfunction : pin_mask

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] tba_r, tba_nxt, oca_r, oca_nxt, ocb_r, ocb_nxt, dt_r, dt_nxt;
  logic [7:0] ovs_r, ovs_nxt, ovv_r, ovv_nxt;
  logic tb_en_r, tb_en_nxt;
  logic [15:0] per_buf_r, per_buf_nxt, sev_r, sev_nxt;
  logic [15:0] duty_buf_r [4];
  logic [15:0] duty_buf_nxt [4];
  logic [TB_W-1:0] per_act_r, per_act_nxt;
  logic [DUTY_W-1:0] duty_act_r [4];
  logic [DUTY_W-1:0] duty_act_nxt [4];
  logic [7:0] ovs_act_r, ovs_act_nxt, ovv_act_r, ovv_act_nxt;
  logic [IRQ_W-1:0] st_r, st_nxt, ien_r, ien_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic do_wr, cnt_wr;

  // Time base state
  logic [7:0] presc_r, presc_nxt;
  logic [TB_W-1:0] cnt_r, cnt_nxt;
  logic dir_r, dir_nxt;
  logic [3:0] post_r, post_nxt, spost_r, spost_nxt;
  logic trig_r, trig_nxt;
  logic tick, top_ev, bot_ev, boundary, period_ev, sev_ev, oneshot_done;
  mpp_tb_mode_t mode;

  assign mode = mpp_tb_mode_t'(tba_r[TBA_MODE_LSB +: 2]);
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign cnt_wr = do_wr && (aw_addr_r == OFS_TB_COUNT);

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  // Prescaled tick, count, boundary and event
  always_comb begin
    tick = tb_en_r && (presc_r == presc_last(tba_r[TBA_PRESC_LSB +: 2])); // R13
    presc_nxt = !tb_en_r ? presc_r : (tick ? 8'h00 : presc_r + 8'h01); // R15
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    top_ev = 1'b0;
    bot_ev = 1'b0;
    if (tick) begin
      if (mode == MPP_FREE || mode == MPP_SINGLE) begin // R8
        dir_nxt = 1'b0;
        if (cnt_r >= per_act_r) begin
          cnt_nxt = '0;
          top_ev = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end else if (!dir_r) begin // R8
        if (cnt_r >= per_act_r) begin
          dir_nxt = 1'b1;
          cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
          top_ev = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end else if (cnt_r == '0) begin
        dir_nxt = 1'b0;
        cnt_nxt = (per_act_r == '0) ? cnt_r : cnt_r + 1'b1;
        bot_ev = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
    if (cnt_wr) begin
      cnt_nxt = w_data_r[TB_W-1:0];
    end
    unique case (mode) // R14
      MPP_FREE, MPP_SINGLE: boundary = top_ev;
      MPP_UPDOWN: boundary = bot_ev;
      MPP_UPDOWN_DBL: boundary = top_ev || bot_ev; // R9
    endcase
    oneshot_done = top_ev && (mode == MPP_SINGLE);
    // Postscaler counts boundaries
    period_ev = boundary && (post_r == tba_r[TBA_POST_LSB +: 4]); // R5
    post_nxt = !boundary ? post_r : (period_ev ? 4'h0 : post_r + 4'h1);
    sev_ev = tick && (cnt_r == sev_r[TB_W-1:0]) && (dir_r == ocb_r[OCB_SDIR_BIT]); // R10
    trig_nxt = sev_ev && (spost_r == ocb_r[OCB_SPOST_LSB +: 4]); // R10
    spost_nxt = !sev_ev ? spost_r : (trig_nxt ? 4'h0 : spost_r + 4'h1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 8'h00;
      cnt_r <= '0;
      dir_r <= 1'b0;
      post_r <= 4'h0;
      spost_r <= 4'h0;
      trig_r <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      post_r <= post_nxt;
      spost_r <= spost_nxt;
      trig_r <= trig_nxt;
    end
  end

  assign special_event_trig = trig_r;

  // ---------------------------------------------------------------
  // Register file and AXI4-Lite slave
  // ---------------------------------------------------------------
  // Address and data in either order; write lands when both held
  always_comb begin
    tba_nxt = tba_r;
    oca_nxt = oca_r;
    ocb_nxt = ocb_r;
    dt_nxt = dt_r;
    ovs_nxt = ovs_r;
    ovv_nxt = ovv_r;
    tb_en_nxt = tb_en_r && !oneshot_done; // R8
    per_buf_nxt = per_buf_r;
    sev_nxt = sev_r;
    duty_buf_nxt = duty_buf_r;
    ien_nxt = ien_r;
    st_nxt = st_r;
    bresp_nxt = bresp_r;
    aw_hold_nxt = aw_hold_r || s_axi_awvalid;
    aw_addr_nxt = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    w_hold_nxt = w_hold_r || s_axi_wvalid;
    w_data_nxt = w_hold_r ? w_data_r : s_axi_wdata;
    w_strb_nxt = w_hold_r ? w_strb_r : s_axi_wstrb;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (aw_addr_r)
        OFS_TB_CTRL_A: tba_nxt = merge8(tba_r, w_data_r, w_strb_r);
        OFS_TB_CTRL_B: if (w_strb_r[0]) tb_en_nxt = w_data_r[TBB_EN_BIT]; // R15
        OFS_OUT_CTRL_A: oca_nxt = merge8(oca_r, w_data_r, w_strb_r);
        OFS_OUT_CTRL_B: ocb_nxt = merge8(ocb_r, w_data_r, w_strb_r);
        OFS_DEADTIME: dt_nxt = merge8(dt_r, w_data_r, w_strb_r);
        OFS_OVR_SEL: ovs_nxt = merge8(ovs_r, w_data_r, w_strb_r); // R11
        OFS_OVR_STATE: ovv_nxt = merge8(ovv_r, w_data_r, w_strb_r); // R11
        OFS_TB_COUNT: ;
        OFS_TB_PERIOD: per_buf_nxt = merge16(per_buf_r, w_data_r, w_strb_r); // R6
        OFS_SEV_CMP: sev_nxt = merge16(sev_r, w_data_r, w_strb_r);
        OFS_IRQ_CLEAR: if (w_strb_r[0]) st_nxt = st_r & ~w_data_r[IRQ_W-1:0];
        OFS_IRQ_ENABLE: if (w_strb_r[0]) ien_nxt = w_data_r[IRQ_W-1:0];
        default: begin
          bresp_nxt = RESP_SLVERR;
          for (int g = 0; g < NUM_GEN; g++) begin
            if (aw_addr_r == OFS_DUTY0 + 7'(4 * g)) begin
              duty_buf_nxt[g] = merge16(duty_buf_r[g], w_data_r, w_strb_r); // R6
              bresp_nxt = RESP_OKAY;
            end
          end
        end
      endcase
    end
    if (!FULL) begin
      oca_nxt[OCA_PAIR_LSB + 3] = 1'b0; // R2
    end
    // Events win over a clear in the same cycle
    st_nxt = st_nxt | {oneshot_done, trig_nxt, period_ev}; // R9
    // Read channel: one read, answered next cycle
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_TB_CTRL_A: rdata_nxt[7:0] = tba_r;
        OFS_TB_CTRL_B: rdata_nxt[7:0] = {tb_en_r, dir_r, 6'h00};
        OFS_OUT_CTRL_A: rdata_nxt[7:0] = oca_r;
        OFS_OUT_CTRL_B: rdata_nxt[7:0] = ocb_r;
        OFS_DEADTIME: rdata_nxt[7:0] = dt_r;
        OFS_OVR_SEL: rdata_nxt[7:0] = ovs_r;
        OFS_OVR_STATE: rdata_nxt[7:0] = ovv_r;
        OFS_TB_COUNT: rdata_nxt[TB_W-1:0] = cnt_r;
        OFS_TB_PERIOD: rdata_nxt[15:0] = per_buf_r;
        OFS_SEV_CMP: rdata_nxt[15:0] = sev_r;
        OFS_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = st_r;
        OFS_IRQ_CLEAR: ;
        OFS_IRQ_ENABLE: rdata_nxt[IRQ_W-1:0] = ien_r;
        default: begin
          rresp_nxt = RESP_SLVERR;
          for (int g = 0; g < NUM_GEN; g++) begin
            if (s_axi_araddr == OFS_DUTY0 + 7'(4 * g)) begin
              rdata_nxt[15:0] = duty_buf_r[g];
              rresp_nxt = RESP_OKAY;
            end
          end
        end
      endcase
    end
    // Active copies follow the buffers only at a boundary, or while stopped
    per_act_nxt = per_act_r;
    duty_act_nxt = duty_act_r;
    if ((boundary || !tb_en_r) && !ocb_r[OCB_UDIS_BIT]) begin // R16
      per_act_nxt = per_buf_r[TB_W-1:0];
      for (int g = 0; g < 4; g++) begin
        duty_act_nxt[g] = duty_buf_r[g][DUTY_W-1:0];
      end
    end
    // Synchronised overrides wait for the boundary to avoid a mid-period glitch
    ovs_act_nxt = ovs_act_r;
    ovv_act_nxt = ovv_act_r;
    if (!ocb_r[OCB_OSYNC_BIT] || boundary || !tb_en_r) begin // R11
      ovs_act_nxt = ovs_r;
      ovv_act_nxt = ovv_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tba_r <= 8'h00;
      oca_r <= OCA_RST;
      ocb_r <= 8'h00;
      dt_r <= 8'h00;
      ovs_r <= OVR_SEL_RST;
      ovv_r <= 8'h00;
      tb_en_r <= 1'b0;
      per_buf_r <= 16'h0000;
      sev_r <= 16'h0000;
      duty_buf_r <= '{default: 16'h0000};
      per_act_r <= '0;
      duty_act_r <= '{default: '0};
      ovs_act_r <= OVR_SEL_RST;
      ovv_act_r <= 8'h00;
      st_r <= '0;
      ien_r <= '0;
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      tba_r <= tba_nxt;
      oca_r <= oca_nxt;
      ocb_r <= ocb_nxt;
      dt_r <= dt_nxt;
      ovs_r <= ovs_nxt;
      ovv_r <= ovv_nxt;
      tb_en_r <= tb_en_nxt;
      per_buf_r <= per_buf_nxt;
      sev_r <= sev_nxt;
      duty_buf_r <= duty_buf_nxt;
      per_act_r <= per_act_nxt;
      duty_act_r <= duty_act_nxt;
      ovs_act_r <= ovs_act_nxt;
      ovv_act_r <= ovv_act_nxt;
      st_r <= st_nxt;
      ien_r <= ien_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = |(st_r & ien_r);

  // ---------------------------------------------------------------
  // Duty generators, pairs and output stage
  // ---------------------------------------------------------------
  logic [7:0] pair_out;
  logic dbg_s1_r, dbg_s2_r;
  logic [7:0] pin_r, pin_nxt, pen_r, pen_nxt;

  for (genvar g = 0; g < 4; g++) begin : gen_pair
    if (g < NUM_GEN) begin : gen_on // R1
      logic demand;
      // Two low bits of the prescaler extend the compare to 14 bits
      assign demand = {cnt_r, presc_r[1:0]} < duty_act_r[g]; // R7
      mpp_deadtime #(.DT_W(DT_W)) u_dead (
        .aclk(aclk),
        .aresetn(aresetn),
        .demand(demand),
        .independent(oca_r[OCA_PAIR_LSB + g]),
        .dead_cycles(dt_r[DT_W-1:0]),
        .out_odd(pair_out[2*g+1]),
        .out_even(pair_out[2*g])
      );
    end else begin : gen_off
      assign pair_out[2*g+1 -: 2] = 2'b00; // R2
    end
  end

  // Debug halt is asynchronous to aclk; two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
    end else begin
      dbg_s1_r <= debug_halt;
      dbg_s2_r <= dbg_s1_r;
    end
  end

  // Override, pin enable and debug masking; inactive level is low
  always_comb begin
    pen_nxt = pin_mask(oca_r[OCA_PEN_LSB +: 3]); // R2
    pin_nxt = ((pair_out & ovs_act_r) | (ovv_act_r & ~ovs_act_r)) & pen_nxt; // R11
    if (dbg_s2_r) begin
      pin_nxt = 8'h00; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 8'h00;
      pen_r <= 8'h00;
    end else begin
      pin_r <= pin_nxt;
      pen_r <= pen_nxt;
    end
  end

  assign pwm_out = pin_r;
  assign pwm_en = pen_r;

endmodule : mpp_core

// File: rtl/mpp_pkg.sv
// Shared constants for the motor power PWM core
package mpp_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFS_TB_CTRL_A = 7'h00;
  localparam logic [6:0] OFS_TB_CTRL_B = 7'h04;
  localparam logic [6:0] OFS_OUT_CTRL_A = 7'h08;
  localparam logic [6:0] OFS_OUT_CTRL_B = 7'h0c;
  localparam logic [6:0] OFS_DEADTIME = 7'h10;
  localparam logic [6:0] OFS_OVR_SEL = 7'h14;
  localparam logic [6:0] OFS_OVR_STATE = 7'h18;
  localparam logic [6:0] OFS_TB_COUNT = 7'h1c;
  localparam logic [6:0] OFS_TB_PERIOD = 7'h20;
  localparam logic [6:0] OFS_SEV_CMP = 7'h24;
  localparam logic [6:0] OFS_DUTY0 = 7'h28;
  localparam logic [6:0] OFS_IRQ_STATUS = 7'h38;
  localparam logic [6:0] OFS_IRQ_CLEAR = 7'h3c;
  localparam logic [6:0] OFS_IRQ_ENABLE = 7'h40;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TBA_MODE_LSB = 0;
  localparam int TBA_PRESC_LSB = 2;
  localparam int TBA_POST_LSB = 4;
  localparam int TBB_EN_BIT = 7;
  localparam int TBB_DIR_BIT = 6;
  localparam int OCA_PAIR_LSB = 0;
  localparam int OCA_PEN_LSB = 4;
  localparam int OCB_OSYNC_BIT = 0;
  localparam int OCB_UDIS_BIT = 1;
  localparam int OCB_SDIR_BIT = 3;
  localparam int OCB_SPOST_LSB = 4;
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_SEVT = 1;
  localparam int IRQ_ONESHOT = 2;
  localparam int IRQ_W = 3;

  // ---------------------------------------------------------------
  // Reset values, widths, responses
  // ---------------------------------------------------------------
  localparam logic [7:0] OCA_RST = 8'h70;
  localparam logic [7:0] OVR_SEL_RST = 8'hff;
  localparam int TB_W = 12;
  localparam int DUTY_W = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MPP_FREE = 2'h0,
    MPP_SINGLE = 2'h1,
    MPP_UPDOWN = 2'h2,
    MPP_UPDOWN_DBL = 2'h3
  } mpp_tb_mode_t;

endpackage : mpp_pkg

// File: rtl/mpp_deadtime.sv
// Dead-time insertion for one output pair
`timescale 1ns/100ps
module mpp_deadtime
  import mpp_pkg::*;
#(
  parameter int DT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic demand,
  input wire logic independent,
  input wire logic [DT_W-1:0] dead_cycles,
  output logic out_odd,
  output logic out_even
);

  logic level_r, level_nxt;
  logic [DT_W-1:0] gap_r, gap_nxt;
  logic odd_r, odd_nxt;
  logic even_r, even_nxt;

  // Both switches stay off while the gap runs after a demand change
  always_comb begin
    level_nxt = demand;
    gap_nxt = gap_r;
    if (independent) begin
      gap_nxt = '0;
    end else if (demand != level_r) begin
      gap_nxt = dead_cycles; // R4
    end else if (gap_r != '0) begin
      gap_nxt = gap_r - 1'b1;
    end
    if (independent) begin
      odd_nxt = demand;
      even_nxt = demand;
    end else begin
      odd_nxt = demand && (demand == level_r) && (gap_r == '0); // R4
      even_nxt = !demand && (demand == level_r) && (gap_r == '0); // R3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= 1'b0;
      gap_r <= '0;
      odd_r <= 1'b0;
      even_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      gap_r <= gap_nxt;
      odd_r <= odd_nxt;
      even_r <= even_nxt;
    end
  end

  assign out_odd = odd_r;
  assign out_even = even_r;

endmodule : mpp_deadtime

// File: bench/mpp_monitor.sv
// Port checker for the PWM core
`timescale 1ns/100ps
module mpp_monitor
  import mpp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_halt,
  input wire logic [7:0] pwm_out,
  input wire logic special_event_trig
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // Two sync flops plus output flop
  halt_force_a: assert property (debug_halt [*4] |=> pwm_out == 8'h00)
    else $error("pins live in halt");
  // Pairs stay complementary in this bench
  pair_excl_a: assert property ((pwm_out & (pwm_out << 1) & 8'haa) == 8'h00)
    else $error("pair both on");
  dead_gap_a: assert property ($fell(pwm_out[1]) |-> !pwm_out[0] ##1 !pwm_out[0])
    else $error("dead gap missing");
  trig_pulse_a: assert property (special_event_trig |=> !special_event_trig)
    else $error("trigger too long");

  cover property (special_event_trig);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  cover property ($fell(pwm_out[1]));
endmodule : mpp_monitor

bind mpp_core mpp_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .debug_halt(debug_halt), .pwm_out(pwm_out), .special_event_trig(special_event_trig));

// File: bench/mpp_bridge_model.sv
// Half-bridge switch model
`timescale 1ns/100ps
module mpp_bridge_model (
  input wire logic aclk,
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_en,
  output int last_on [8],
  output int shoot_total
);
  int run [8];

  // Last on-pulse width per switch
  always @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      run[i] <= pwm_out[i] ? run[i] + 1 : 0;
      if (!pwm_out[i] && run[i] != 0) last_on[i] <= run[i];
    end
    // Both switches of a leg on
    if ((pwm_out & pwm_en & (pwm_out << 1) & 8'haa) != 8'h00) shoot_total <= shoot_total + 1;
  end
endmodule : mpp_bridge_model

// File: bench/tb_top.sv
// Self-checking PWM core bench
`timescale 1ns/100ps
module tb_top;
  import mpp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [6:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, debug_halt = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, trig, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pwm_out, pwm_en;
  int last_on [8];
  int shoot_total;
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rq_d [$];
  logic [1:0] rq_r [$];
  logic [1:0] bq [$];

  // ---------------------------------------------------------------
  // Clock, design and switch model
  // ---------------------------------------------------------------
  always #2 aclk = ~aclk;

  mpp_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .debug_halt(debug_halt), .pwm_out(pwm_out), .pwm_en(pwm_en),
    .special_event_trig(trig), .irq(irq));

  mpp_bridge_model sw_u (.aclk(aclk), .pwm_out(pwm_out), .pwm_en(pwm_en), .last_on(last_on),
    .shoot_total(shoot_total));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Ready sampled at the falling edge
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic sa, sw, sb;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(negedge aclk);
      if (!(awvalid || wvalid || bready)) break;
      sa = awready;
      sw = wready;
      sb = bvalid;
      @(posedge aclk);
      if (sa) awvalid <= 0;
      if (sw) wvalid <= 0;
      if (sb) bready <= 0;
    end
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic sa, sb;
    @(posedge aclk);
    rq_d.push_back(d);
    rq_r.push_back(r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(negedge aclk);
      if (!(arvalid || rready)) break;
      sa = arready;
      sb = rvalid;
      @(posedge aclk);
      if (sa) arvalid <= 0;
      if (sb) rready <= 0;
    end
  endtask : rd

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // Watcher: oldest note per answer
  always @(negedge aclk) begin
    if (rvalid && rready && rq_d.size() > 0) begin
      chk(rdata, rq_d.pop_front());
      chk(32'(rresp), 32'(rq_r.pop_front()));
    end
    if (bvalid && bready && bq.size() > 0) chk(32'(bresp), 32'(bq.pop_front()));
  end

  // Watchdog
  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int n, t, e;
    v = $urandom(76217);
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(OFS_OUT_CTRL_A, 32'(OCA_RST));
    rd(OFS_OVR_SEL, 32'(OVR_SEL_RST));
    rd(OFS_TB_CTRL_B, 32'h0);
    rd(7'h44, 32'h0, RESP_SLVERR);
    wr(7'h44, 32'h5a, RESP_SLVERR);
    done("reset");
    // Period, compare, duties
    for (int i = 0; i < 6; i++) begin
      v = $urandom() & 32'hffff;
      wr(OFS_TB_PERIOD + 7'(4 * i), v);
      rd(OFS_TB_PERIOD + 7'(4 * i), v);
    end
    v = $urandom();
    wr(OFS_TB_COUNT, v & 32'hffff);
    rd(OFS_TB_COUNT, v & 32'hfff);
    done("registers");
    // Free running, period 9, duty 16, gap 2+1
    wr(OFS_DEADTIME, 32'h2);
    wr(OFS_OUT_CTRL_A, 32'h50);
    wr(OFS_TB_COUNT, 32'h0);
    wr(OFS_TB_PERIOD, 32'h9);
    wr(OFS_DUTY0, 32'h10);
    wr(OFS_SEV_CMP, 32'hfff);
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_TB_CTRL_A, 32'h0);
    wr(OFS_TB_CTRL_B, 32'h80);
    for (n = 0; n < 400 && !irq; n++) @(posedge aclk);
    chk(32'(irq), 32'h1);
    repeat (200) @(posedge aclk);
    chk(32'(last_on[1]), 32'd13);
    chk(32'(last_on[0]), 32'd21);
    rd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    chk(32'(irq), 32'h0);
    debug_halt <= 1;
    repeat (6) @(posedge aclk);
    chk(32'(pwm_out), 32'h0);
    debug_halt <= 0;
    wr(OFS_IRQ_ENABLE, 32'h2);
    wr(OFS_SEV_CMP, 32'h3);
    for (n = 0; n < 400 && !trig; n++) @(posedge aclk);
    chk(32'(trig), 32'h1);
    rd(OFS_IRQ_STATUS, 32'h3);
    chk(32'(irq), 32'h1);
    done("running");
    // Override pair 0
    wr(OFS_TB_CTRL_B, 32'h0);
    wr(OFS_OVR_STATE, 32'h2);
    wr(OFS_OVR_SEL, 32'hfc);
    repeat (4) @(posedge aclk);
    chk(32'(pwm_out[1:0]), 32'h2);
    wr(OFS_OVR_STATE, 32'h0);
    repeat (4) @(posedge aclk);
    chk(32'(pwm_out[1:0]), 32'h0);
    wr(OFS_OVR_SEL, 32'hff);
    done("override");
    // Mode m, prescale m: first boundary
    wr(OFS_IRQ_ENABLE, 32'h5);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_TB_COUNT, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h7);
      wr(OFS_TB_CTRL_A, 32'(m * 5));
      wr(OFS_TB_CTRL_B, 32'h80);
      for (n = 0; n < 4000 && !irq; n++) @(posedge aclk);
      t = 4 << (2 * m);
      e = (m == 2) ? 20 : 10;
      chk(32'(n >= (e - 2) * t && n <= (e + 1) * t + 16), 32'h1);
      if (m == 1) rd(OFS_TB_CTRL_B, 32'h0);
      wr(OFS_TB_CTRL_B, 32'h0);
    end
    chk(32'(shoot_total), 32'h0);
    done("modes");
    final_report();
  end
endmodule : tb_top
